// file: src/fpet_consts.svh
/*
 * Timing constants for the flash program and erase sequencer.
 * Assumes a single 250 MHz system clock and a timing generator tick derived from it.
 */
`ifndef FPET_CONSTS_SVH
`define FPET_CONSTS_SVH

`define FPET_SYS_CLK_KHZ        250000
`define FPET_FTG_MIN_KHZ        257
`define FPET_FTG_MAX_KHZ        476
`define FPET_DIV_MIN            ((`FPET_SYS_CLK_KHZ + `FPET_FTG_MAX_KHZ - 1) / `FPET_FTG_MAX_KHZ)
`define FPET_DIV_MAX            (`FPET_SYS_CLK_KHZ / `FPET_FTG_MIN_KHZ)

`define FPET_CNT_W              13
`define FPET_DIV_W              10
`define FPET_IDX_W              6
`define FPET_ADDR_W             16
`define FPET_DATA_W             16

`define FPET_T_WORD             13'h0023
`define FPET_T_BLK_FIRST        13'h001E
`define FPET_T_BLK_NEXT         13'h0015
`define FPET_T_BLK_END          13'h0006
`define FPET_T_MASS_ERASE       13'h14B1
`define FPET_T_SEG_ERASE        13'h12D3
`define FPET_IDX_LAST           6'h3F

`endif

// file: src/fpet_pkg.sv
/*
 * Types for the flash program and erase sequencer.
 * Assumes nothing beyond the constants header.
 */
package fpet_pkg;

	typedef enum logic [1:0] {
		FPET_OP_WORD  = 2'h0,
		FPET_OP_BLOCK = 2'h1,
		FPET_OP_MASS  = 2'h2,
		FPET_OP_SEG   = 2'h3
	} fpet_op_t;

	typedef enum logic [7:0] {
		FPET_ST_IDLE      = 8'h01,
		FPET_ST_WORD      = 8'h02,
		FPET_ST_BLK_FIRST = 8'h04,
		FPET_ST_BLK_WAIT  = 8'h08,
		FPET_ST_BLK_NEXT  = 8'h10,
		FPET_ST_BLK_END   = 8'h20,
		FPET_ST_MASS      = 8'h40,
		FPET_ST_SEG       = 8'h80
	} fpet_state_t;

endpackage

// file: src/fpet_tick_if.sv
/*
 * Link between the sequencer and its timing generator divider.
 * Assumes both ends sit on the same system clock.
 */
`timescale 1ns/10ps
`include "fpet_consts.svh"

interface fpet_tick_if;
	logic                   run;
	logic [`FPET_DIV_W-1:0] div;
	logic                   tick;

	modport seq (output run, output div, input tick);
	modport gen (input run, input div, output tick);
endinterface

// file: src/fpet_tick_gen.sv
/*
 * Timing generator: one tick every div+1 system clocks while run is high.
 * Assumes div is held stable while run is high.
 */
`timescale 1ns/10ps
`include "fpet_consts.svh"

module fpet_tick_gen
	import fpet_pkg::*;
(
	input  wire logic clock,
	input  wire logic srst,
	fpet_tick_if.gen  tk
);

	logic [`FPET_DIV_W-1:0] cnt_r;
	logic [`FPET_DIV_W-1:0] cnt_nxt;
	logic                   tick_r;
	logic                   tick_nxt;

	assign tk.tick = tick_r;

	// restart on every run so each phase begins on a whole timing period
	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = 1'b0;
		if (!tk.run) begin
			cnt_nxt = '0;
		end else if (cnt_r >= tk.div) begin
			cnt_nxt  = '0;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + `FPET_DIV_W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

endmodule

// file: src/fpet_top.sv
/*
 * Flash program and erase sequencer: times word program, block program,
 * mass erase and segment erase in ticks of a divided timing clock.
 * Assumes start, op and word inputs come from logic on the same clock and
 * that software picks a divider inside the legal timing clock range.
 */
`timescale 1ns/10ps
`include "fpet_consts.svh"

module fpet_top
	import fpet_pkg::*;
(
	input  wire logic                    clock,
	input  wire logic                    srst,
	input  wire logic [`FPET_DIV_W-1:0]  ftg_div,
	input  wire logic                    start,
	input  wire logic [1:0]              op,
	input  wire logic [`FPET_ADDR_W-1:0] wr_addr,
	input  wire logic [`FPET_DATA_W-1:0] wr_data,
	input  wire logic                    wr_valid,
	input  wire logic                    blk_end,
	output logic                         busy,
	output logic                         done,
	output logic                         next_ready,
	output logic                         prog_en,
	output logic                         erase_en,
	output logic                         mass_en,
	output logic [`FPET_ADDR_W-1:0]      arr_addr,
	output logic [`FPET_DATA_W-1:0]      arr_data
);

	fpet_tick_if tk ();

	fpet_tick_gen u_tick (
		.clock (clock),
		.srst  (srst),
		.tk    (tk)
	);

	fpet_state_t              state_r;
	fpet_state_t              state_nxt;
	logic [`FPET_CNT_W-1:0]   cnt_r;
	logic [`FPET_CNT_W-1:0]   cnt_nxt;
	logic [`FPET_IDX_W-1:0]   idx_r;
	logic [`FPET_IDX_W-1:0]   idx_nxt;
	logic [`FPET_DIV_W-1:0]   div_r;
	logic [`FPET_DIV_W-1:0]   div_nxt;
	logic [`FPET_ADDR_W-1:0]  addr_r;
	logic [`FPET_ADDR_W-1:0]  addr_nxt;
	logic [`FPET_DATA_W-1:0]  data_r;
	logic [`FPET_DATA_W-1:0]  data_nxt;
	logic                     busy_r;
	logic                     busy_nxt;
	logic                     done_r;
	logic                     done_nxt;
	logic                     ready_r;
	logic                     ready_nxt;
	logic                     prog_r;
	logic                     prog_nxt;
	logic                     erase_r;
	logic                     erase_nxt;
	logic                     mass_r;
	logic                     mass_nxt;
	logic                     run_r;
	logic                     run_nxt;
	logic                     phase_end;

	assign tk.run     = run_r;
	assign tk.div     = div_r;
	assign phase_end  = tk.tick && (cnt_r == `FPET_CNT_W'(1));

	assign busy       = busy_r;
	assign done       = done_r;
	assign next_ready = ready_r;
	assign prog_en    = prog_r;
	assign erase_en   = erase_r;
	assign mass_en    = mass_r;
	assign arr_addr   = addr_r;
	assign arr_data   = data_r;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		idx_nxt   = idx_r;
		div_nxt   = div_r;
		addr_nxt  = addr_r;
		data_nxt  = data_r;
		done_nxt  = 1'b0;
		if (tk.tick && cnt_r != '0) begin
			cnt_nxt = cnt_r - `FPET_CNT_W'(1);
		end
		case (state_r)
			FPET_ST_IDLE: begin
				if (start) begin
					div_nxt  = ftg_div;
					addr_nxt = wr_addr;
					data_nxt = wr_data;
					idx_nxt  = '0;
					case (fpet_op_t'(op))
						FPET_OP_WORD: begin
							state_nxt = FPET_ST_WORD;
							cnt_nxt   = `FPET_T_WORD;
						end
						FPET_OP_BLOCK: begin
							state_nxt = FPET_ST_BLK_FIRST;
							cnt_nxt   = `FPET_T_BLK_FIRST;
						end
						FPET_OP_MASS: begin
							state_nxt = FPET_ST_MASS;
							cnt_nxt   = `FPET_T_MASS_ERASE;
						end
						default: begin
							state_nxt = FPET_ST_SEG;
							cnt_nxt   = `FPET_T_SEG_ERASE;
						end
					endcase
				end
			end
			FPET_ST_WORD, FPET_ST_MASS, FPET_ST_SEG: begin
				if (phase_end) begin
					state_nxt = FPET_ST_IDLE;
					done_nxt  = 1'b1;
				end
			end
			FPET_ST_BLK_FIRST, FPET_ST_BLK_NEXT: begin
				if (phase_end) begin
					if (idx_r == `FPET_IDX_LAST) begin
						state_nxt = FPET_ST_BLK_END;
						cnt_nxt   = `FPET_T_BLK_END;
					end else begin
						state_nxt = FPET_ST_BLK_WAIT;
					end
				end
			end
			FPET_ST_BLK_WAIT: begin
				// end request wins over a word offered in the same cycle
				if (blk_end) begin
					state_nxt = FPET_ST_BLK_END;
					cnt_nxt   = `FPET_T_BLK_END;
				end else if (wr_valid) begin
					state_nxt = FPET_ST_BLK_NEXT;
					cnt_nxt   = `FPET_T_BLK_NEXT;
					idx_nxt   = idx_r + `FPET_IDX_W'(1);
					addr_nxt  = wr_addr;
					data_nxt  = wr_data;
				end
			end
			FPET_ST_BLK_END: begin
				if (phase_end) begin
					state_nxt = FPET_ST_IDLE;
					done_nxt  = 1'b1;
				end
			end
			default: begin
				state_nxt = FPET_ST_IDLE;
				cnt_nxt   = '0;
			end
		endcase
	end

	// outputs decoded from the next state so each one leaves a flip-flop
	always_comb begin
		busy_nxt  = (state_nxt != FPET_ST_IDLE);
		ready_nxt = (state_nxt == FPET_ST_BLK_WAIT);
		prog_nxt  = (state_nxt == FPET_ST_WORD) || (state_nxt == FPET_ST_BLK_FIRST)
			|| (state_nxt == FPET_ST_BLK_NEXT);
		erase_nxt = (state_nxt == FPET_ST_MASS) || (state_nxt == FPET_ST_SEG);
		mass_nxt  = (state_nxt == FPET_ST_MASS);
		// timing clock runs only during counted phases, so waits cost no ticks
		run_nxt   = busy_nxt && (state_nxt != FPET_ST_BLK_WAIT);
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_r <= FPET_ST_IDLE;
			cnt_r   <= '0;
			idx_r   <= '0;
			div_r   <= '0;
			addr_r  <= '0;
			data_r  <= '0;
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
			ready_r <= 1'b0;
			prog_r  <= 1'b0;
			erase_r <= 1'b0;
			mass_r  <= 1'b0;
			run_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			idx_r   <= idx_nxt;
			div_r   <= div_nxt;
			addr_r  <= addr_nxt;
			data_r  <= data_nxt;
			busy_r  <= busy_nxt;
			done_r  <= done_nxt;
			ready_r <= ready_nxt;
			prog_r  <= prog_nxt;
			erase_r <= erase_nxt;
			mass_r  <= mass_nxt;
			run_r   <= run_nxt;
		end
	end

endmodule

// file: test/fpet_top_sva.sv
/* checker on the sequencer top ports.
   assumes it is bound onto fpet_top. */
`timescale 1ns/10ps
`include "fpet_consts.svh"
module fpet_top_sva
	import fpet_pkg::*;
(
	input wire logic                    clock,
	input wire logic                    srst,
	input wire logic                    start,
	input wire logic [1:0]              op,
	input wire logic [`FPET_ADDR_W-1:0] wr_addr,
	input wire logic                    wr_valid,
	input wire logic                    blk_end,
	input wire logic                    busy,
	input wire logic                    done,
	input wire logic                    next_ready,
	input wire logic                    prog_en,
	input wire logic                    erase_en,
	input wire logic                    mass_en,
	input wire logic [`FPET_ADDR_W-1:0] arr_addr
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	a_busy_on_start: assert property (start && !busy |=> busy) else $error("busy late");
	a_done_ends_op: assert property (done |-> !busy && !prog_en && !erase_en) else $error("done early");
	a_done_pulse: assert property (done |=> !done) else $error("done long");
	a_prog_alone: assert property (prog_en |-> busy && !erase_en) else $error("prog stray");
	a_mass_erases: assert property (mass_en |-> erase_en) else $error("mass stray");
	a_addr_latch: assert property (start && !busy |=> arr_addr == $past(wr_addr)) else $error("addr");
	a_addr_hold: assert property (busy && !next_ready |=> $stable(arr_addr)) else $error("addr moved");
	a_ready_leaves: assert property (next_ready && (wr_valid || blk_end) |=> !next_ready && busy)
		else $error("ready stuck");
	a_prog_span: assert property ($rose(prog_en) |-> prog_en[*8]) else $error("prog short");
	a_erase_span: assert property ($rose(erase_en) |-> erase_en[*8]) else $error("erase short");
	a_prog_select: assert property (start && !busy && !op[1] |=> prog_en && !erase_en)
		else $error("no prog phase");
	a_mass_select: assert property (start && !busy && op == 2'h2 |=> mass_en && erase_en)
		else $error("no mass erase");
	a_seg_select: assert property (start && !busy && op == 2'h3 |=> erase_en && !mass_en)
		else $error("no segment erase");
endmodule

// file: test/fpet_flash_model.sv
/* flash array model: programming only clears bits, erase sets all.
   assumes the sequencer controls on one clock. */
`timescale 1ns/10ps
`include "fpet_consts.svh"
module fpet_flash_model
	import fpet_pkg::*;
(
	input wire logic                    clock,
	input wire logic                    prog_en,
	input wire logic                    erase_en,
	input wire logic [`FPET_ADDR_W-1:0] arr_addr,
	input wire logic [`FPET_DATA_W-1:0] arr_data
);
	logic [15:0] mem [256];
	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	// anding is idempotent, so a long phase commits the same word
	always @(posedge clock) begin
		if (prog_en)
			mem[arr_addr[7:0]] <= mem[arr_addr[7:0]] & arr_data;
		if (erase_en)
			foreach (mem[i]) mem[i] <= 16'hFFFF;
	end
endmodule

// file: test/tb_flash_program_erase_timing.sv
/* bench for the sequencer: phase lengths are taken as differences
   between two dividers, so fixed latency offsets cancel.
   assumes the flash array model as far side. */
`timescale 1ns/10ps
`include "fpet_consts.svh"
module tb_flash_program_erase_timing
	import fpet_pkg::*;
;
	logic                   clock, srst, start, wr_valid, blk_end, busy, done, next_ready, prog_en, erase_en, mass_en;
	logic [1:0]             op;
	logic [`FPET_DIV_W-1:0] ftg_div;
	logic [15:0]            wr_addr, wr_data, arr_addr, arr_data;
	int                     n_mismatch = 0, comparisons = 0, a, b, c, k, t0[3], t1[3];
	fpet_top dut (.clock(clock), .srst(srst), .ftg_div(ftg_div), .start(start), .op(op), .wr_addr(wr_addr),
		.wr_data(wr_data), .wr_valid(wr_valid), .blk_end(blk_end), .busy(busy), .done(done),
		.next_ready(next_ready), .prog_en(prog_en), .erase_en(erase_en), .mass_en(mass_en),
		.arr_addr(arr_addr), .arr_data(arr_data));
	fpet_flash_model fl (.clock(clock), .prog_en(prog_en), .erase_en(erase_en), .arr_addr(arr_addr),
		.arr_data(arr_data));
	initial begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task summarize;
		if (n_mismatch == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wt(input bit r, output int n);
		n = 0;
		while (!(done === 1'b1 || (r && next_ready === 1'b1)) && n < 20000) begin
			@(negedge clock);
			n++;
		end
		if (n == 20000) n_mismatch++;
	endtask
	task automatic go(input logic [1:0] o, input logic [9:0] d, input logic [15:0] ad, output int n);
		{op, ftg_div, wr_addr, wr_data, start} = {o, d, ad, ~ad, 1'b1};
		@(negedge clock) start = 0;
		wt(o == 2'h1, n);
	endtask
	task automatic feed(input bit e, input logic [15:0] ad, output int n);
		{wr_valid, blk_end, wr_addr, wr_data} = {~e, e, ad, ~ad};
		@(negedge clock) {wr_valid, blk_end} = 2'b00;
		wt(!e, n);
	endtask
	task t_word;
		go(0, 1, 16'h0005, a);
		chk(fl.mem[5], 16'hFFFA);
		fork
			go(0, 2, 16'h0006, b);
			begin
				repeat (10) @(negedge clock);
				{op, start} = 3'b111;
				@(negedge clock) start = 0;
			end
		join
		chk(b - a, 35);
		chk(fl.mem[6], 16'hFFF9);
		go(0, `FPET_DIV_MIN - 1, 16'h0007, c);
		chk(c - a, 35 * `FPET_DIV_MIN - 70);
		chk(fl.mem[7], 16'hFFF8);
	endtask
	task t_reset;
		{op, ftg_div, start} = {2'h2, 10'h000, 1'b1};
		@(negedge clock) start = 0;
		repeat (20) @(negedge clock);
		srst = 1;
		repeat (3) @(negedge clock);
		srst = 0;
		chk({busy, done, next_ready, prog_en, erase_en, mass_en}, 0);
		go(0, 0, 16'h0008, a);
		chk(fl.mem[8], 16'hFFF7);
	endtask
	task t_block(input logic [9:0] d, output int t[3]);
		go(1, d, 16'h0010, t[0]);
		feed(0, 16'h0011, t[1]);
		feed(1, 16'h0000, t[2]);
	endtask
	task t_full;
		go(1, 0, 16'h0040, a);
		k = 0;
		while (done !== 1'b1 && k < 70) begin
			feed(0, 16'h0041 + k[15:0], a);
			k++;
		end
		chk(k, 63);
	endtask
	task t_erase(input logic [1:0] o, input int n);
		go(0, 0, 16'h0005, c);
		go(o, 0, 16'h0000, a);
		go(o, 1, 16'h0000, b);
		chk(b - a, n);
		chk(fl.mem[5], 16'hFFFF);
	endtask
	initial begin
		{srst, start, wr_valid, blk_end, op, ftg_div, wr_addr, wr_data} = {1'b1, 47'h0};
		repeat (3) @(negedge clock);
		srst = 0;
		chk({busy, done, next_ready, prog_en, erase_en, mass_en}, 0);
		t_word;
		t_block(0, t0);
		t_block(1, t1);
		chk(t1[0] - t0[0], 30);
		chk(t1[1] - t0[1], 21);
		chk(t1[2] - t0[2], 6);
		chk(fl.mem[17], 16'hFFEE);
		t_full;
		t_erase(2, 5297);
		t_erase(3, 4819);
		t_reset;
		summarize;
	end
	initial begin
		#300000;
		n_mismatch++;
		summarize;
	end
endmodule
bind fpet_top fpet_top_sva chk_i (.clock(clock), .srst(srst), .start(start), .op(op), .wr_addr(wr_addr),
	.wr_valid(wr_valid), .blk_end(blk_end), .busy(busy), .done(done), .next_ready(next_ready),
	.prog_en(prog_en), .erase_en(erase_en), .mass_en(mass_en), .arr_addr(arr_addr));
